// ### rtl/tout_timing_out.v
/*
 * timing output block: four user pulses, eight-pin crosspoint with drive
 * and polarity, custom clock ratio shadows with update toggles, custom
 * format timing loading and the custom reference period check.
 * assumes preset timing inputs and pclk_en come from logic on clk, and a
 * host port that presents one register access per cycle.
 */
`timescale 1ns/1ps
`include "tout_defines.vh"
module tout_timing_out
#(
  parameter HAS_AUDIO = 1,
  parameter [31:0] DEF_SEL = `TOUT_RST_SEL,
  parameter REF_MAX_CYC = `TOUT_REF_MAX_US * `TOUT_CLK_MHZ
)
(
  input wire clk,
  input wire nrst,
  input wire pclk_en,
  input wire [5:0] video_format_select,
  input wire interlaced,
  input wire pre_hsync,
  input wire pre_hblank,
  input wire pre_vsync,
  input wire pre_vblank,
  input wire fsync,
  input wire fdigital,
  input wire ten_field_marker,
  input wire active_video_flag,
  input wire audio_frame_pulse,
  input wire ref_hsync,
  input wire host_wr,
  input wire host_rd,
  input wire [11:0] host_addr,
  input wire [15:0] host_wdata,
  output wire [15:0] host_rdata,
  output wire host_rvalid,
  output wire [7:0] tout_o,
  output wire [7:0] tout_oe_n,
  output wire [7:0] tout_drive_hi,
  output wire [31:0] video_ratio_num,
  output wire [31:0] video_ratio_den,
  output wire [31:0] audio_ratio_num,
  output wire [31:0] audio_ratio_den,
  output wire [5:0] audio_mult_sel,
  output wire triple_rate_audio_enable,
  output wire video_ratio_range_err,
  output wire custom_timing_active,
  output wire ref_stable
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  localparam [19:0] REF_MAX = REF_MAX_CYC[19:0];
  integer i;
  reg [15:0] lock_r, aud_ctl_r, pol_r;
  reg [31:0] vnum_sh_r, vden_sh_r, anum_sh_r, aden_sh_r;
  reg [31:0] vnum_r, vden_r, anum_r, aden_r;
  reg [15:0] amul_r [0:2];
  reg [15:0] sel_r [0:7];
  reg [15:0] ct_sh_r [0:7];
  reg [15:0] ct_r [0:7];
  reg [15:0] up_r [0:19];
  reg vupd_seen_r, aupd_seen_r;
  reg [7:0] ct_mask_r;
  reg custom_run_r;
  reg [5:0] fmt_m_r, fmt_r, fmt_prev_r;
  wire is_custom = (fmt_r == `TOUT_FMT_CUSTOM);
  wire enter_custom = is_custom && (fmt_prev_r != `TOUT_FMT_CUSTOM);
  wire [11:0] amul_off = host_addr - `TOUT_A_AMUL_BASE;
  wire [11:0] sel_off = host_addr - `TOUT_A_SEL_BASE;
  wire [11:0] ct_off = host_addr - `TOUT_A_CT_BASE;
  wire [11:0] up_off = host_addr - `TOUT_A_UP_BASE;
  wire amul_hit = (host_addr >= `TOUT_A_AMUL_BASE) && (amul_off < `TOUT_AMUL_NUM);
  wire sel_hit = (host_addr >= `TOUT_A_SEL_BASE) && (sel_off < `TOUT_SEL_NUM);
  wire ct_hit = (host_addr >= `TOUT_A_CT_BASE) && (ct_off < `TOUT_CT_NUM);
  wire up_hit = (host_addr >= `TOUT_A_UP_BASE) && (up_off < `TOUT_UP_NUM);
  // only writable while the custom format is selected
  wire ct_wr = host_wr && ct_hit && is_custom;
  reg [7:0] ct_mask_nxt;

  always @*
  begin
    // set wins over the entry clear
    ct_mask_nxt = enter_custom ? 8'h00 : ct_mask_r;
    if (ct_wr)
    begin
      ct_mask_nxt[ct_off[2:0]] = 1'b1;
    end
  end

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      lock_r <= `TOUT_RST_WORD;
      aud_ctl_r <= `TOUT_RST_WORD;
      pol_r <= `TOUT_RST_WORD;
      vnum_sh_r <= 32'h00000000;
      vden_sh_r <= 32'h00000000;
      anum_sh_r <= 32'h00000000;
      aden_sh_r <= 32'h00000000;
      vnum_r <= 32'h00000000;
      vden_r <= 32'h00000000;
      anum_r <= 32'h00000000;
      aden_r <= 32'h00000000;
      vupd_seen_r <= 1'b0;
      aupd_seen_r <= 1'b0;
      ct_mask_r <= 8'h00;
      custom_run_r <= 1'b0;
      fmt_m_r <= 6'h00;
      fmt_r <= 6'h00;
      fmt_prev_r <= 6'h00;
      for (i = 0; i < 3; i = i + 1)
        amul_r[i] <= `TOUT_RST_WORD;
      for (i = 0; i < 8; i = i + 1)
      begin
        sel_r[i] <= {12'h000, DEF_SEL[i*4 +: 4]};
        ct_sh_r[i] <= `TOUT_RST_WORD;
        ct_r[i] <= `TOUT_RST_WORD;
      end
      for (i = 0; i < 20; i = i + 1)
        up_r[i] <= `TOUT_RST_WORD;
    end
    else
    begin
      fmt_m_r <= video_format_select;
      fmt_r <= fmt_m_r;
      fmt_prev_r <= fmt_r;
      if (host_wr)
      begin
        case (host_addr)
          `TOUT_A_LOCK_UPD: lock_r <= host_wdata;
          `TOUT_A_VNUM_LO: vnum_sh_r[15:0] <= host_wdata;
          `TOUT_A_VNUM_HI: vnum_sh_r[31:16] <= host_wdata;
          `TOUT_A_VDEN_LO: vden_sh_r[15:0] <= host_wdata;
          `TOUT_A_VDEN_HI: vden_sh_r[31:16] <= host_wdata;
          `TOUT_A_AUD_CTL: aud_ctl_r <= host_wdata;
          `TOUT_A_ANUM_LO: anum_sh_r[15:0] <= host_wdata;
          `TOUT_A_ANUM_HI: anum_sh_r[31:16] <= host_wdata;
          `TOUT_A_ADEN_LO: aden_sh_r[15:0] <= host_wdata;
          `TOUT_A_ADEN_HI: aden_sh_r[31:16] <= host_wdata;
          `TOUT_A_POL: pol_r <= host_wdata;
          default:
          begin
            if (amul_hit)
              amul_r[amul_off[1:0]] <= host_wdata;
            if (sel_hit)
              sel_r[sel_off[2:0]] <= host_wdata;
            if (ct_wr)
              ct_sh_r[ct_off[2:0]] <= host_wdata;
            if (up_hit)
              up_r[up_off[4:0]] <= host_wdata;
          end
        endcase
      end
      // ratios are held in shadows until the update bit flips
      if (lock_r[`TOUT_UPD_BIT] != vupd_seen_r)
      begin
        vupd_seen_r <= lock_r[`TOUT_UPD_BIT];
        vnum_r <= vnum_sh_r;
        vden_r <= vden_sh_r;
      end
      if (aud_ctl_r[`TOUT_UPD_BIT] != aupd_seen_r)
      begin
        aupd_seen_r <= aud_ctl_r[`TOUT_UPD_BIT];
        anum_r <= anum_sh_r;
        aden_r <= aden_sh_r;
      end
      // previous timing runs until all eight are written
      if (!is_custom || enter_custom)
        custom_run_r <= 1'b0;
      if (is_custom && (ct_mask_nxt == 8'hff))
      begin
        for (i = 0; i < 8; i = i + 1)
          ct_r[i] <= ct_sh_r[i];
        ct_r[ct_off[2:0]] <= host_wdata;
        custom_run_r <= 1'b1;
        ct_mask_r <= 8'h00;
      end
      else
        ct_mask_r <= ct_mask_nxt;
    end
  end

  // ----------------------------------------
  // video ratio range check
  // ----------------------------------------
  // limit is on the delivered ratio; output dividers reach 3.375 MHz outside
  wire [63:0] v_fout = {32'h00000000, vnum_r} * `TOUT_FIN_KHZ;
  wire [63:0] v_lo = {32'h00000000, vden_r} * `TOUT_FMIN_KHZ;
  wire [63:0] v_hi = {32'h00000000, vden_r} * `TOUT_FMAX_KHZ;
  reg vrange_err_r;
  always @(posedge clk)
  begin
    if (!nrst)
      vrange_err_r <= 1'b0;
    else
      vrange_err_r <= (vden_r == 32'h00000000) || (v_fout < v_lo) || (v_fout > v_hi);
  end

  // ----------------------------------------
  // custom timing generator
  // ----------------------------------------
  // only the period follows the clock; counts stay as programmed
  reg [15:0] chc_r, clc_r;
  wire h_wrap = (chc_r >= ct_r[0]);
  always @(posedge clk)
  begin
    if (!nrst || !custom_run_r)
    begin
      chc_r <= 16'h0001;
      clc_r <= 16'h0001;
    end
    else if (pclk_en)
    begin
      chc_r <= h_wrap ? 16'h0001 : chc_r + 16'h0001;
      if (h_wrap)
        clc_r <= (clc_r >= ct_r[3]) ? 16'h0001 : clc_r + 16'h0001;
    end
  end
  wire c_hsync = (chc_r <= ct_r[1]);
  wire c_hblank = (chc_r <= ct_r[2]);
  wire c_vblank = (clc_r <= ct_r[5]);
  wire [15:0] vs_first = ct_r[7] + 16'h0001;
  wire c_vsync = (clc_r >= vs_first) && (clc_r < vs_first + ct_r[4]);
  wire s_hsync = custom_run_r ? c_hsync : pre_hsync;
  wire s_hblank = custom_run_r ? c_hblank : pre_hblank;
  wire s_vsync = custom_run_r ? c_vsync : pre_vsync;
  wire s_vblank = custom_run_r ? c_vblank : pre_vblank;
  wire s_de = custom_run_r ? (!c_hblank && !c_vblank) : active_video_flag;

  // ----------------------------------------
  // user pulses
  // ----------------------------------------
  reg [15:0] hcnt_r, lcnt_r;
  reg hb_prev_r, vb_prev_r;
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      hcnt_r <= 16'h0000;
      lcnt_r <= 16'h0000;
      hb_prev_r <= 1'b0;
      vb_prev_r <= 1'b0;
    end
    else if (pclk_en)
    begin
      hb_prev_r <= s_hblank;
      // counts start at 1 on the blanking leading edges
      hcnt_r <= (s_hblank && !hb_prev_r) ? 16'h0001 : hcnt_r + 16'h0001;
      if (s_hblank && !hb_prev_r)
      begin
        vb_prev_r <= s_vblank;
        lcnt_r <= (s_vblank && !vb_prev_r) ? 16'h0001 : lcnt_r + 16'h0001;
      end
    end
  end

  wire even_field = interlaced && fdigital;
  reg [3:0] user_r;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_user
      wire [15:0] hs = up_r[g*`TOUT_UP_REGS];
      wire [15:0] he = up_r[g*`TOUT_UP_REGS+1];
      wire [15:0] vs = up_r[g*`TOUT_UP_REGS+2];
      wire [15:0] ve = up_r[g*`TOUT_UP_REGS+3];
      wire [15:0] ctl = up_r[g*`TOUT_UP_REGS+4];
      // a start of 1 is inclusive, so pixel 2 can never open a pulse
      wire h_win = (hs == 16'h0001) ? (hcnt_r >= hs && hcnt_r <= he) : (hcnt_r > hs && hcnt_r <= he);
      wire [15:0] vs_e = even_field ? vs - 16'h0001 : vs;
      wire [15:0] ve_e = even_field ? ve - 16'h0001 : ve;
      wire v_win = (lcnt_r >= vs_e) && (lcnt_r <= ve_e);
      wire act = ctl[`TOUT_UPC_AND] ? (h_win && v_win) :
                 ctl[`TOUT_UPC_OR] ? (h_win || v_win) :
                 ctl[`TOUT_UPC_XOR] ? (h_win ^ v_win) : h_win;
      always @(posedge clk)
      begin
        if (!nrst)
          user_r[g] <= 1'b1;
        else
          user_r[g] <= ctl[`TOUT_UPC_POL] ? act : !act;
      end
    end
  endgenerate

  // ----------------------------------------
  // crosspoint
  // ----------------------------------------
  wire afs_src = (HAS_AUDIO != 0) ? audio_frame_pulse : 1'b0;
  wire [15:0] src = {1'b0, user_r, afs_src, 1'b0, s_de, ten_field_marker, fdigital, fsync,
                     s_vblank, s_vsync, s_hblank, s_hsync, 1'b0};
  reg [7:0] tout_r, oe_n_r, drv_r;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_pin
      wire [3:0] code = sel_r[g][3:0];
      wire hiz = (code == `TOUT_SEL_HIZ) || (code == `TOUT_SEL_RSV0) || (code == `TOUT_SEL_RSV1) ||
                 ((code == `TOUT_SEL_AUDIO) && (HAS_AUDIO == 0));
      always @(posedge clk)
      begin
        if (!nrst)
        begin
          tout_r[g] <= 1'b0;
          oe_n_r[g] <= 1'b1;
          drv_r[g] <= 1'b0;
        end
        else
        begin
          tout_r[g] <= src[code] ^ pol_r[g];
          oe_n_r[g] <= hiz;
          drv_r[g] <= sel_r[g][`TOUT_SEL_DRV_BIT];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // custom reference check
  // ----------------------------------------
  reg ref_m_r, ref_s_r, ref_d_r, stable_r;
  reg [19:0] per_r, last_r;
  wire ref_rise = ref_s_r && !ref_d_r;
  wire [19:0] per_diff = (per_r > last_r) ? per_r - last_r : last_r - per_r;
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      ref_m_r <= 1'b0;
      ref_s_r <= 1'b0;
      ref_d_r <= 1'b0;
      stable_r <= 1'b0;
      per_r <= 20'h00000;
      last_r <= 20'h00000;
    end
    else
    begin
      ref_m_r <= ref_hsync;
      ref_s_r <= ref_m_r;
      ref_d_r <= ref_s_r;
      if (ref_rise)
      begin
        per_r <= 20'h00001;
        last_r <= per_r;
        // one cycle of jitter tolerated between periods
        stable_r <= (per_r < REF_MAX) && (per_diff <= 20'h00001);
      end
      else if (per_r >= REF_MAX)
        stable_r <= 1'b0;
      else
        per_r <= per_r + 20'h00001;
    end
  end

  // ----------------------------------------
  // read back
  // ----------------------------------------
  reg [15:0] rd_nxt, rdata_r;
  reg rvalid_r;
  always @*
  begin
    case (host_addr)
      `TOUT_A_LOCK_UPD: rd_nxt = lock_r;
      `TOUT_A_VNUM_LO: rd_nxt = vnum_sh_r[15:0];
      `TOUT_A_VNUM_HI: rd_nxt = vnum_sh_r[31:16];
      `TOUT_A_VDEN_LO: rd_nxt = vden_sh_r[15:0];
      `TOUT_A_VDEN_HI: rd_nxt = vden_sh_r[31:16];
      `TOUT_A_AUD_CTL: rd_nxt = aud_ctl_r;
      `TOUT_A_ANUM_LO: rd_nxt = anum_sh_r[15:0];
      `TOUT_A_ANUM_HI: rd_nxt = anum_sh_r[31:16];
      `TOUT_A_ADEN_LO: rd_nxt = aden_sh_r[15:0];
      `TOUT_A_ADEN_HI: rd_nxt = aden_sh_r[31:16];
      `TOUT_A_POL: rd_nxt = pol_r;
      `TOUT_A_STATUS: rd_nxt = {5'h00, ct_mask_r, vrange_err_r, stable_r, custom_run_r};
      default:
      begin
        rd_nxt = 16'h0000;
        if (amul_hit)
          rd_nxt = amul_r[amul_off[1:0]];
        if (sel_hit)
          rd_nxt = sel_r[sel_off[2:0]];
        if (ct_hit)
          rd_nxt = ct_sh_r[ct_off[2:0]];
        if (up_hit)
          rd_nxt = up_r[up_off[4:0]];
      end
    endcase
  end

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= host_rd;
      if (host_rd)
        rdata_r <= rd_nxt;
    end
  end

  assign host_rdata = rdata_r;
  assign host_rvalid = rvalid_r;
  assign tout_o = tout_r;
  assign tout_oe_n = oe_n_r;
  assign tout_drive_hi = drv_r;
  assign video_ratio_num = vnum_r;
  assign video_ratio_den = vden_r;
  assign audio_ratio_num = anum_r;
  assign audio_ratio_den = aden_r;
  assign audio_mult_sel = {amul_r[2][1:0], amul_r[1][1:0], amul_r[0][1:0]};
  assign triple_rate_audio_enable = aud_ctl_r[`TOUT_TRIPLE_BIT];
  assign video_ratio_range_err = vrange_err_r;
  assign custom_timing_active = custom_run_r;
  assign ref_stable = stable_r;
endmodule

// ### rtl/tout_defines.vh
/*
 * constants of the timing output block: register offsets, field positions,
 * reset values, selector codes and timing figures.
 * assumes inclusion by bare name from the design files.
 */
`ifndef TOUT_DEFINES_VH
`define TOUT_DEFINES_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define TOUT_A_LOCK_UPD 12'h016
`define TOUT_A_VNUM_LO 12'h020
`define TOUT_A_VNUM_HI 12'h021
`define TOUT_A_VDEN_LO 12'h022
`define TOUT_A_VDEN_HI 12'h023
`define TOUT_A_AUD_CTL 12'h031
`define TOUT_A_ANUM_LO 12'h033
`define TOUT_A_ANUM_HI 12'h034
`define TOUT_A_ADEN_LO 12'h035
`define TOUT_A_ADEN_HI 12'h036
`define TOUT_A_AMUL_BASE 12'h03f
`define TOUT_A_SEL_BASE 12'h043
`define TOUT_A_POL 12'h04b
`define TOUT_A_CT_BASE 12'h04e
`define TOUT_A_UP_BASE 12'h057
`define TOUT_A_STATUS 12'h0f0
// ----------------------------------------
// counts and fields
// ----------------------------------------
`define TOUT_AMUL_NUM 12'h003
`define TOUT_SEL_NUM 12'h008
`define TOUT_CT_NUM 12'h008
`define TOUT_UP_NUM 12'h014
`define TOUT_UP_REGS 5
`define TOUT_UPD_BIT 6
`define TOUT_TRIPLE_BIT 5
`define TOUT_SEL_DRV_BIT 4
`define TOUT_UPC_POL 0
`define TOUT_UPC_AND 1
`define TOUT_UPC_OR 2
`define TOUT_UPC_XOR 3
`define TOUT_FMT_CUSTOM 6'h3e
`define TOUT_RST_WORD 16'h0000
`define TOUT_RST_SEL 32'h87654321
// ----------------------------------------
// selector codes
// ----------------------------------------
`define TOUT_SEL_HIZ 4'h0
`define TOUT_SEL_RSV0 4'h9
`define TOUT_SEL_AUDIO 4'ha
`define TOUT_SEL_RSV1 4'hf
// ----------------------------------------
// timing figures
// ----------------------------------------
`define TOUT_CLK_MHZ 250
`define TOUT_REF_MAX_US 2400
`define TOUT_FIN_KHZ 27000
`define TOUT_FMIN_KHZ 13500
`define TOUT_FMAX_KHZ 165000
`endif

// ### tb/tout_chk.sv
/* concurrent checks on the timing output block ports.
   assumes a bind onto tout_timing_out, one clock, nrst synchronous low. */
`timescale 1ns/1ps
module tout_chk
#(
  parameter REF_MAX_CYC = 600000
)
(
  input wire clk,
  input wire nrst,
  input wire host_wr,
  input wire host_rd,
  input wire [11:0] host_addr,
  input wire [15:0] host_wdata,
  input wire host_rvalid,
  input wire pre_hsync,
  input wire ref_hsync,
  input wire [5:0] video_format_select,
  input wire [7:0] tout_o,
  input wire [7:0] tout_oe_n,
  input wire [7:0] tout_drive_hi,
  input wire [31:0] video_ratio_num,
  input wire [31:0] audio_ratio_num,
  input wire custom_timing_active,
  input wire ref_stable
);
  // ----------------------------------------
  // helper mirrors of pin 1 routing
  // ----------------------------------------
  reg [3:0] sel0_r;
  reg pol0_r;
  reg [31:0] gap_r;
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      sel0_r <= 4'h1;
      pol0_r <= 1'b0;
      gap_r <= 32'h0;
    end
    else
    begin
      if (host_wr && host_addr == 12'h043)
        sel0_r <= host_wdata[3:0];
      if (host_wr && host_addr == 12'h04b)
        pol0_r <= host_wdata[0];
      // low time only: a lower bound on the gap since the last rising edge
      gap_r <= ref_hsync ? 32'h0 : gap_r + 32'h1;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_rd_answer; host_rd |=> host_rvalid; endproperty
  property p_rd_quiet; !host_rd |=> !host_rvalid; endproperty
  property p_vid_hold; $past(nrst) && $changed(video_ratio_num) |-> $past(host_wr && host_addr == 12'h016, 2);
  endproperty
  property p_aud_hold; $past(nrst) && $changed(audio_ratio_num) |-> $past(host_wr && host_addr == 12'h031, 2);
  endproperty
  property p_hiz; host_wr && host_addr == 12'h043 && host_wdata[3:0] == 4'h0 |-> ##2 tout_oe_n[0]; endproperty
  property p_rsv; host_wr && host_addr == 12'h043 && (host_wdata[3:0] == 4'h9 || host_wdata[3:0] == 4'hf)
    |-> ##2 tout_oe_n[0]; endproperty
  property p_driven; host_wr && host_addr == 12'h043 && host_wdata[3:0] != 4'h0 && host_wdata[3:0] <= 4'h8
    |-> ##2 !tout_oe_n[0]; endproperty
  property p_drive; host_wr && host_addr == 12'h043 |-> ##2 tout_drive_hi[0] == $past(host_wdata[4], 2);
  endproperty
  property p_route; $past(nrst) && $past(nrst, 2) && sel0_r == 4'h1
    |=> tout_o[0] == ($past(pre_hsync) ^ $past(pol0_r)); endproperty
  // format pins reach the decode two edges late, three before the rise; the load completes on the sampled write
  property p_custom_go; $rose(custom_timing_active) |-> $past(video_format_select == 6'h3e, 3)
    && $past(host_wr && host_addr >= 12'h04e && host_addr <= 12'h055, 1); endproperty
  property p_ref_lost; gap_r > REF_MAX_CYC + 8 |-> !ref_stable; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  a_rd_quiet: assert property (p_rd_quiet) else $error("answer without read");
  a_vid_hold: assert property (p_vid_hold) else $error("video ratio moved without toggle");
  a_aud_hold: assert property (p_aud_hold) else $error("audio ratio moved without toggle");
  a_hiz: assert property (p_hiz) else $error("code zero pin driven");
  a_rsv: assert property (p_rsv) else $error("reserved code pin driven");
  a_driven: assert property (p_driven) else $error("selected pin not driven");
  a_drive: assert property (p_drive) else $error("drive strength wrong");
  a_route: assert property (p_route) else $error("pin 1 not hsync xor polarity");
  a_custom_go: assert property (p_custom_go) else $error("custom timing without load");
  a_ref_lost: assert property (p_ref_lost) else $error("reference stable after loss");
  c_read: cover property (host_rd && host_addr == 12'h057);
  c_custom: cover property ($rose(custom_timing_active));
  c_lost: cover property ($fell(ref_stable));
endmodule
bind tout_timing_out tout_chk #(.REF_MAX_CYC(REF_MAX_CYC)) u_chk
(
  .clk(clk), .nrst(nrst), .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
  .host_wdata(host_wdata), .host_rvalid(host_rvalid), .pre_hsync(pre_hsync), .ref_hsync(ref_hsync),
  .video_format_select(video_format_select), .tout_o(tout_o), .tout_oe_n(tout_oe_n),
  .tout_drive_hi(tout_drive_hi), .video_ratio_num(video_ratio_num), .audio_ratio_num(audio_ratio_num),
  .custom_timing_active(custom_timing_active), .ref_stable(ref_stable)
);

// ### tb/tout_pin_sink.sv
/* downstream logic seen from the timing output pins.
   assumes no pull on the board, so a released pin floats. */
`timescale 1ns/1ps
module tout_pin_sink
(
  input wire [7:0] tout_o,
  input wire [7:0] tout_oe_n,
  output wire [7:0] pin
);
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_pin
      assign pin[i] = tout_oe_n[i] ? 1'bz : tout_o[i];
    end
  endgenerate
endmodule

// ### tb/tout_timing_out_tb_top.sv
/* self-checking bench for the timing output block.
   assumes the pin sink model and the bound checker. */
`timescale 1ns/1ps
module tout_timing_out_tb_top;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [5:0] fmt = 6'h00;
  reg [8:0] src = 9'h15a;
  reg run = 1'b0;
  reg ilace = 1'b0;
  reg [3:0] px = 4'h0;
  reg [2:0] ln = 3'h0;
  reg ref_h = 1'b0;
  reg wr_s = 1'b0;
  reg rd_s = 1'b0;
  reg [11:0] addr = 12'h000;
  reg [15:0] wdata = 16'h0000;
  wire [15:0] rdata;
  wire rvalid;
  wire [7:0] t_o, oe_n, drv, pin;
  wire [31:0] vnum, vden, anum, aden;
  wire [5:0] amul;
  wire tri3, rerr, cact, rstab;
  integer bad_count = 0;
  integer num_checks = 0;
  integer cyc = 0;
  integer c;
  // frame of 16 pixels by 8 lines when running
  wire hs = run ? (px < 4'h2) : src[0];
  wire hb = run ? (px < 4'h4) : src[1];
  wire vs = run ? (ln == 3'h0) : src[2];
  wire vb = run ? (ln < 3'h2) : src[3];
  tout_timing_out #(.REF_MAX_CYC(200)) u_dut
  (
    .clk(clk), .nrst(nrst), .pclk_en(1'b1), .video_format_select(fmt), .interlaced(ilace),
    .pre_hsync(hs), .pre_hblank(hb), .pre_vsync(vs), .pre_vblank(vb), .fsync(src[4]), .fdigital(src[5]),
    .ten_field_marker(src[6]), .active_video_flag(src[7]), .audio_frame_pulse(src[8]), .ref_hsync(ref_h),
    .host_wr(wr_s), .host_rd(rd_s), .host_addr(addr), .host_wdata(wdata), .host_rdata(rdata),
    .host_rvalid(rvalid), .tout_o(t_o), .tout_oe_n(oe_n), .tout_drive_hi(drv), .video_ratio_num(vnum),
    .video_ratio_den(vden), .audio_ratio_num(anum), .audio_ratio_den(aden), .audio_mult_sel(amul),
    .triple_rate_audio_enable(tri3), .video_ratio_range_err(rerr), .custom_timing_active(cact),
    .ref_stable(rstab)
  );
  tout_pin_sink u_sink
  (
    .tout_o(t_o), .tout_oe_n(oe_n), .pin(pin)
  );
  // ----------------------------------------
  // clock, frame counters, timeout
  // ----------------------------------------
  initial
  begin
    forever #2 clk = ~clk;
  end
  always @(negedge clk)
  begin
    px <= px + 4'h1;
    if (px == 4'hf)
      ln <= ln + 3'h1;
  end
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      bad_count = bad_count + 1;
      stop_test;
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task stop_test;
  begin
    if (bad_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("ERROR %0t mismatch got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task wait_n(input integer n);
  begin
    repeat (n) @(negedge clk);
  end
  endtask
  task wr(input [11:0] a, input [15:0] d);
  begin
    @(negedge clk);
    wr_s = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_s = 1'b0;
  end
  endtask
  task rd(input [11:0] a, input [15:0] exp);
  begin
    @(negedge clk);
    rd_s = 1'b1;
    addr = a;
    @(negedge clk);
    rd_s = 1'b0;
    chk(rvalid, 1);
    chk(rdata, exp);
  end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
  begin
    rd(12'h043, 16'h0001);
    rd(12'h04a, 16'h0008);
    rd(12'h04b, 16'h0000);
    rd(12'h100, 16'h0000);
    chk(oe_n, 8'h00);
    chk(drv, 8'h00);
  end
  endtask
  task t_xpoint;
  begin
    for (c = 0; c < 16; c = c + 1)
    begin
      wr(12'h043, c[15:0]);
      wait_n(3);
      chk(oe_n[0], (c == 0) || (c == 9) || (c == 15));
      if (c == 0 || c == 9 || c == 15)
        chk(pin[0], 1'bz);
      else if (c <= 10)
        chk(t_o[0], src[(c == 10) ? 8 : c - 1]);
    end
    // one source on two pins, one inverted, the other driven hard
    wr(12'h044, 16'h0013);
    wr(12'h043, 16'h0003);
    wr(12'h04b, 16'h0001);
    wait_n(3);
    chk(t_o[1:0], {src[2], ~src[2]});
    chk(drv[1:0], 2'b10);
    wr(12'h04b, 16'h0000);
    wr(12'h044, 16'h0002);
  end
  endtask
  task t_vclk;
  begin
    // 74.25 over 27 in lowest terms
    wr(12'h020, 16'h000b);
    wr(12'h021, 16'h0000);
    wr(12'h022, 16'h0004);
    wr(12'h023, 16'h0000);
    wait_n(4);
    chk(vnum, 32'h0);
    rd(12'h020, 16'h000b);
    wr(12'h016, 16'h0040);
    wait_n(3);
    chk({vnum[15:0], vden[15:0]}, 32'h000b0004);
    chk(rerr, 0);
    // 0.5 MHz lies below the accepted range
    wr(12'h020, 16'h0001);
    wr(12'h022, 16'h0036);
    wr(12'h016, 16'h0000);
    wait_n(3);
    chk(vden, 32'h36);
    chk(rerr, 1);
  end
  endtask
  task t_aclk;
  begin
    // 42 kHz: 1792 over 1125, rate select custom, 384fs low
    wr(12'h033, 16'h0700);
    wr(12'h035, 16'h0465);
    wr(12'h03f, 16'h0003);
    wr(12'h040, 16'h0000);
    wr(12'h041, 16'h0002);
    wait_n(3);
    chk(anum, 32'h0);
    wr(12'h031, 16'h0040);
    wait_n(3);
    chk({anum[15:0], aden[15:0]}, 32'h07000465);
    chk(amul, 6'h23);
    chk(tri3, 0);
  end
  endtask
  task t_user(input [15:0] hs0, input [15:0] he0, input [15:0] v0, input [15:0] ctl, input [31:0] exp);
    integer n;
  begin
    n = 0;
    wr(12'h057, hs0);
    wr(12'h058, he0);
    wr(12'h059, v0);
    wr(12'h05a, v0 + 16'h0001);
    wr(12'h05b, ctl);
    rd(12'h057, hs0);
    wait_n(256);
    // any 128 cycles hold exactly one frame, so alignment does not matter
    repeat (128)
    begin
      @(negedge clk);
      if (t_o[0] === 1'b0)
        n = n + 1;
    end
    chk(n, exp);
  end
  endtask
  task t_custom;
    integer n;
  begin
    n = 0;
    wr(12'h04e, 16'h0010);
    rd(12'h04e, 16'h0000);
    fmt = 6'h3e;
    wait_n(6);
    for (c = 0; c < 8; c = c + 1)
    begin
      wr(12'h04e + c[11:0], (c == 0) ? 16'h0010 : (c == 3) ? 16'h0008 : 16'h0002);
      wait_n(3);
      chk(cact, c == 7);
    end
    rd(12'h04e, 16'h0010);
    // custom vsync on lines 3 and 4 of a 16 by 8 frame
    wr(12'h044, 16'h0003);
    wait_n(4);
    repeat (128)
    begin
      @(negedge clk);
      if (t_o[1] === 1'b1)
        n = n + 1;
    end
    chk(n, 32);
  end
  endtask
  task t_ref;
  begin
    repeat (6)
    begin
      ref_h = 1'b1;
      wait_n(50);
      ref_h = 1'b0;
      wait_n(50);
    end
    chk(rstab, 1);
    wait_n(300);
    chk(rstab, 0);
  end
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    wait_n(3);
    t_reset;
    t_xpoint;
    t_vclk;
    t_aclk;
    run = 1'b1;
    wr(12'h043, 16'h000b);
    t_user(16'h0003, 16'h0007, 16'h0003, 16'h0000, 32);
    t_user(16'h0001, 16'h0005, 16'h0003, 16'h0000, 40);
    t_user(16'h0003, 16'h0007, 16'h0003, 16'h0001, 96);
    t_user(16'h0003, 16'h0007, 16'h0003, 16'h0002, 8);
    t_user(16'h0003, 16'h0007, 16'h0003, 16'h0004, 56);
    t_user(16'h0003, 16'h0007, 16'h0003, 16'h0008, 48);
    // even field: window moves up a line, only line 1 is left
    ilace = 1'b1;
    src[5] = 1'b1;
    t_user(16'h0003, 16'h0007, 16'h0001, 16'h0002, 4);
    ilace = 1'b0;
    src[5] = 1'b0;
    t_custom;
    t_ref;
    stop_test;
  end
endmodule
